// ==== hw/hub_config_power_control.v ====
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "hub_cfg_defs.vh"

module hub_config_power_control #(
    parameter [15:0] DEF_VID = 16'h1a2b, // Arbitrary value.
    parameter [15:0] DEF_PID = 16'h3c4d, // Arbitrary value.
    parameter [15:0] DEF_DID = 16'h0100, // Arbitrary value.
    parameter integer OC_TICK_CYCLES = `OC_STEP_MS * `CLK_KHZ,
    parameter integer DETACH_CYCLES = `DETACH_MS * `CLK_KHZ
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hready,
    input wire [31:0] hwdata,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire config_source_select_hi,
    input wire config_source_select_mid,
    input wire config_source_select_lo,
    input wire local_supply_sense,
    input wire indicator_strap,
    input wire per_port_translator_strap,
    input wire common_power_switch_strap,
    input wire [1:0] fixed_device_port_straps,
    input wire [1:0] port_off_straps,
    input wire switch_polarity_strap,
    input wire upstream_supply_sense,
    input wire host_single_translator,
    input wire [3:0] port_power_request,
    input wire [3:0] over_current_in,
    input wire frame_start,
    input wire frame_eof1,
    input wire downstream_traffic,
    output reg [3:0] port_power_switch_outputs,
    output reg upstream_attach,
    output reg pullup_power,
    output reg [15:0] vendor_id,
    output reg [15:0] product_id,
    output reg [15:0] device_id,
    output reg self_powered,
    output reg hs_disabled,
    output reg multi_translator,
    output reg indicator_enable,
    output reg [1:0] sense_mode,
    output reg per_port_power,
    output reg compound_device,
    output reg [3:0] fixed_ports,
    output reg [3:0] disabled_ports,
    output reg [7:0] max_power,
    output reg [7:0] hub_current,
    output reg [7:0] power_on_time,
    output reg [3:0] over_current_report,
    output reg eop_send
);

    localparam [4:0] S_SAMPLE = 5'b00001;
    localparam [4:0] S_LOAD = 5'b00010;
    localparam [4:0] S_APPLY = 5'b00100;
    localparam [4:0] S_RUN = 5'b01000;
    localparam [4:0] S_DETACH = 5'b10000;

    reg [4:0] state_q;
    reg [2:0] src_q;
    reg def_mode_q, polarity_q, sense_last_q, wr_pend_q, rd_pend_q, tick_q, traffic_seen_q;
    reg [15:0] img_q [0:13];
    reg [7:0] c1_q, c2_q, nonrem_q, pds_q, pdb_q, mps_q, mpb_q, hcs_q, hcb_q, oct_q;
    reg [31:0] wait_q, tick_cnt_q;
    reg [3:0] wr_idx_q, rd_idx_q, strap_off, strap_fixed;
    wire addr_ok;
    wire [3:0] port_on, oc_src;
    integer k;

    // Image-wide reset words; the 8-bit option fields take their low byte on purpose.
    localparam [15:0] CFG2_W = `RST_CFG2;
    localparam [15:0] MAXP_SELF_W = `RST_MAXP_SELF;
    localparam [15:0] MAXP_BUS_W = `RST_MAXP_BUS;
    localparam [15:0] PON_TIME_W = `RST_PON_TIME;
    localparam [15:0] OC_TIME_W = `RST_OC_TIME;

    // The port-off decoder fills from port 4 downward and the fixed-port decoder from port 1 upward, so a strap value can never name a gap.
    always @* begin
        case (port_off_straps)
            2'b01: strap_off = 4'b1000;
            2'b10: strap_off = 4'b1100;
            2'b11: strap_off = 4'b1110;
            default: strap_off = 4'b0000;
        endcase
        case (fixed_device_port_straps)
            2'b01: strap_fixed = 4'b0001;
            2'b10: strap_fixed = 4'b0011;
            2'b11: strap_fixed = 4'b0111;
            default: strap_fixed = 4'b0000;
        endcase
    end

    // Reset contents of each image word.
    function [15:0] img_reset;
        input [3:0] idx;
        begin
            case (idx)
                `R_VID: img_reset = DEF_VID;
                `R_PID: img_reset = DEF_PID;
                `R_DID: img_reset = DEF_DID;
                `R_CFG1: img_reset = `RST_CFG1;
                `R_CFG2: img_reset = `RST_CFG2;
                `R_MAXP_SELF: img_reset = `RST_MAXP_SELF;
                `R_MAXP_BUS: img_reset = `RST_MAXP_BUS;
                `R_HCC_SELF: img_reset = `RST_MAXP_SELF;
                `R_HCC_BUS: img_reset = `RST_MAXP_BUS;
                `R_PON_TIME: img_reset = `RST_PON_TIME;
                `R_OC_TIME: img_reset = `RST_OC_TIME;
                default: img_reset = 16'h0000;
            endcase
        end
    endfunction

    // Only whole-word transfers inside the sixteen-word window are mapped.
    assign addr_ok = (haddr[31:6] == 26'h0000000) && (hsize == 3'b010);

    // Bus slave: writes land at the end of their data phase, reads take one wait state
    // so that a read right behind a write sees the written value.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= 4'h0;
            rd_pend_q <= 1'b0;
            rd_idx_q <= 4'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
        end else begin
            hresp <= 1'b0;
            if (rd_pend_q) begin
                rd_pend_q <= 1'b0;
                hreadyout <= 1'b1;
                hrdata <= 32'h00000000;
                if (rd_idx_q <= `R_OC_TIME) begin
                    hrdata <= {16'h0000, img_q[rd_idx_q]};
                end else if (rd_idx_q == `R_STATUS) begin
                    hrdata <= {16'h0000, 3'b000, state_q, src_q, upstream_supply_sense,
                               local_supply_sense, self_powered, upstream_attach, def_mode_q};
                end
            end
            wr_pend_q <= 1'b0;
            if (hsel && hready && htrans[1] && addr_ok) begin
                if (hwrite) begin
                    wr_pend_q <= 1'b1;
                    wr_idx_q <= haddr[5:2];
                end else begin
                    rd_pend_q <= 1'b1;
                    rd_idx_q <= haddr[5:2];
                    hreadyout <= 1'b0;
                end
            end else if (hsel && hready && htrans[1] && !hwrite) begin
                // Unmapped reads take the same wait state and return the zero word.
                rd_pend_q <= 1'b1;
                rd_idx_q <= `R_CTRL;
                hreadyout <= 1'b0;
            end
        end
    end

    // Image words are open to the external loader only while loading is in progress.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (k = 0; k < 14; k = k + 1) begin
                img_q[k] <= img_reset(k[3:0]);
            end
        end else if (wr_pend_q && state_q == S_LOAD && wr_idx_q <= `R_OC_TIME) begin
            img_q[wr_idx_q] <= hwdata[15:0];
        end
    end

    // Sequencer: straps, load, apply, run, and the dynamic power detach.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= S_SAMPLE;
            src_q <= 3'b000;
            def_mode_q <= 1'b1;
            polarity_q <= 1'b1;
            {c1_q, c2_q, nonrem_q, pds_q, pdb_q} <= 40'h0000000000;
            {mps_q, mpb_q, hcs_q, hcb_q, oct_q, power_on_time} <= 48'h000000000000;
            {vendor_id, product_id, device_id} <= 48'h000000000000;
            self_powered <= 1'b0;
            sense_last_q <= 1'b0;
            wait_q <= 32'h00000000;
        end else begin
            sense_last_q <= local_supply_sense;
            case (state_q)
                S_SAMPLE: begin
                    src_q <= {config_source_select_hi, config_source_select_mid,
                              config_source_select_lo};
                    polarity_q <= switch_polarity_strap;
                    if ({config_source_select_hi, config_source_select_mid,
                         config_source_select_lo} == `SRC_SMBUS ||
                        {config_source_select_hi, config_source_select_mid,
                         config_source_select_lo} == `SRC_EEPROM) begin
                        def_mode_q <= 1'b0;
                        state_q <= S_LOAD;
                    end else begin
                        def_mode_q <= 1'b1;
                        state_q <= S_APPLY;
                    end
                end
                S_LOAD: begin
                    if (wr_pend_q && wr_idx_q == `R_CTRL && hwdata[`CTRL_DONE]) begin
                        state_q <= S_APPLY;
                    end
                end
                S_APPLY: begin
                    if (def_mode_q) begin
                        vendor_id <= DEF_VID;
                        product_id <= DEF_PID;
                        device_id <= DEF_DID;
                        self_powered <= local_supply_sense;
                        c1_q <= {local_supply_sense, 1'b0, per_port_translator_strap, 1'b0, 2'b00,
                                 ~common_power_switch_strap, indicator_strap};
                        c2_q <= {CFG2_W[7], |strap_fixed, 6'h00};
                        nonrem_q <= {4'h0, strap_fixed};
                        pds_q <= {4'h0, strap_off};
                        pdb_q <= {4'h0, strap_off};
                        mps_q <= MAXP_SELF_W[7:0];
                        mpb_q <= MAXP_BUS_W[7:0];
                        hcs_q <= MAXP_SELF_W[7:0];
                        hcb_q <= MAXP_BUS_W[7:0];
                        oct_q <= OC_TIME_W[7:0];
                        power_on_time <= PON_TIME_W[7:0];
                    end else begin
                        vendor_id <= img_q[`R_VID];
                        product_id <= img_q[`R_PID];
                        device_id <= img_q[`R_DID];
                        c1_q <= img_q[`R_CFG1][7:0];
                        c2_q <= img_q[`R_CFG2][7:0];
                        self_powered <= img_q[`R_CFG2][`C2_DYN] ? local_supply_sense
                                                                : img_q[`R_CFG1][`C1_SELF];
                        nonrem_q <= img_q[`R_NONREM][7:0];
                        pds_q <= img_q[`R_PDIS_SELF][7:0];
                        pdb_q <= img_q[`R_PDIS_BUS][7:0];
                        mps_q <= img_q[`R_MAXP_SELF][7:0];
                        mpb_q <= img_q[`R_MAXP_BUS][7:0];
                        hcs_q <= img_q[`R_HCC_SELF][7:0];
                        hcb_q <= img_q[`R_HCC_BUS][7:0];
                        oct_q <= img_q[`R_OC_TIME][7:0];
                        power_on_time <= img_q[`R_PON_TIME][7:0];
                    end
                    state_q <= S_RUN;
                end
                S_RUN: begin
                    if (c2_q[`C2_DYN] && (local_supply_sense != sense_last_q)) begin
                        wait_q <= 32'h00000000;
                        state_q <= S_DETACH;
                    end
                end
                S_DETACH: begin
                    // A further supply change restarts the quiet time.
                    if (local_supply_sense != sense_last_q) begin
                        wait_q <= 32'h00000000;
                    end else if (wait_q >= DETACH_CYCLES - 1) begin
                        self_powered <= local_supply_sense;
                        state_q <= S_RUN;
                    end else begin
                        wait_q <= wait_q + 32'h00000001;
                    end
                end
                default: begin
                    state_q <= S_SAMPLE;
                end
            endcase
        end
    end

    // Free-running 2 ms tick used by the over-current filters.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_q <= 32'h00000000;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (tick_cnt_q == OC_TICK_CYCLES - 1);
            if (tick_cnt_q == OC_TICK_CYCLES - 1) begin
                tick_cnt_q <= 32'h00000000;
            end else begin
                tick_cnt_q <= tick_cnt_q + 32'h00000001;
            end
        end
    end

    // Ganged sensing folds every port onto one shared condition; none masks it all.
    assign oc_src = (sense_mode == `SENSE_GANGED) ? {4{|over_current_in}} :
                    (sense_mode == `SENSE_PORT) ? over_current_in : 4'h0;

    // Ganged switching turns every enabled port on together. Built from the applied fields, not from
    // the derived outputs, so no port is powered for a cycle under a stale mask after a mode change.
    assign port_on = (state_q == S_RUN) ? ((c1_q[`C1_PERPORT] ? port_power_request : {4{|port_power_request}})
                     & ~(self_powered ? pds_q[3:0] : pdb_q[3:0])) : 4'h0;

    genvar p;
    generate
        for (p = 0; p < 4; p = p + 1) begin : g_port
            reg [7:0] oc_cnt_q;
            // The report waits a whole number of ticks, so its delay may run short by up to one tick.
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    oc_cnt_q <= 8'h00;
                    over_current_report[p] <= 1'b0;
                    port_power_switch_outputs[p] <= 1'b0;
                end else begin
                    if (!oc_src[p] || state_q != S_RUN) begin
                        oc_cnt_q <= 8'h00;
                        over_current_report[p] <= 1'b0;
                    end else if (oc_cnt_q >= oct_q) begin
                        over_current_report[p] <= 1'b1;
                    end else if (tick_q) begin
                        oc_cnt_q <= oc_cnt_q + 8'h01;
                    end
                    port_power_switch_outputs[p] <= ~(port_on[p] ^ polarity_q);
                end
            end
        end
    endgenerate

    // Derived option outputs and the upstream connection.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {hs_disabled, multi_translator, indicator_enable, per_port_power, compound_device} <= 5'h00;
            sense_mode <= `SENSE_NONE;
            {fixed_ports, disabled_ports, max_power, hub_current} <= 24'h000000;
            {upstream_attach, pullup_power, traffic_seen_q, eop_send} <= 4'h0;
        end else begin
            hs_disabled <= c1_q[`C1_HS_DIS];
            multi_translator <= c1_q[`C1_MTT] & ~host_single_translator;
            indicator_enable <= c1_q[`C1_LED];
            if (def_mode_q) begin
                sense_mode <= self_powered ? `SENSE_GANGED : `SENSE_NONE;
            end else begin
                sense_mode <= c1_q[`C1_SENSE_HI] ? `SENSE_NONE : {1'b0, c1_q[`C1_SENSE_LO]};
            end
            per_port_power <= c1_q[`C1_PERPORT];
            compound_device <= c2_q[`C2_COMPOUND];
            fixed_ports <= nonrem_q[3:0];
            disabled_ports <= self_powered ? pds_q[3:0] : pdb_q[3:0];
            max_power <= self_powered ? mps_q : mpb_q;
            hub_current <= self_powered ? hcs_q : hcb_q;
            upstream_attach <= (state_q == S_RUN);
            // Dropping the pull-up within one cycle keeps well inside the allowed removal time.
            pullup_power <= (state_q == S_RUN) && upstream_supply_sense;
            // Traffic is tracked per frame; an EOP goes out at EOF1 only on a silent full-speed frame.
            // Traffic in the frame-start cycle belongs to the new frame, so the set wins.
            if (downstream_traffic) begin
                traffic_seen_q <= 1'b1;
            end else if (frame_start) begin
                traffic_seen_q <= 1'b0;
            end
            eop_send <= frame_eof1 && c1_q[`C1_EOP] && c1_q[`C1_HS_DIS] && !traffic_seen_q &&
                        !downstream_traffic && (state_q == S_RUN);
        end
    end

endmodule
`default_nettype wire

// ==== hw/hub_cfg_defs.vh ====
`ifndef HUB_CFG_DEFS_VH
`define HUB_CFG_DEFS_VH

// Clock rate and time steps.
`define CLK_KHZ 20000
`define OC_STEP_MS 2
`define DETACH_MS 10

// Register word indices; byte address is four times the index.
`define R_VID 4'h0
`define R_PID 4'h1
`define R_DID 4'h2
`define R_CFG1 4'h3
`define R_CFG2 4'h4
`define R_NONREM 4'h5
`define R_PDIS_SELF 4'h6
`define R_PDIS_BUS 4'h7
`define R_MAXP_SELF 4'h8
`define R_MAXP_BUS 4'h9
`define R_HCC_SELF 4'ha
`define R_HCC_BUS 4'hb
`define R_PON_TIME 4'hc
`define R_OC_TIME 4'hd
`define R_CTRL 4'he
`define R_STATUS 4'hf

// Reset values of the configuration image.
`define RST_CFG1 16'h0098
`define RST_CFG1_BUS 8'h1c
`define RST_CFG2 16'h0090
`define RST_MAXP_SELF 16'h0001
`define RST_MAXP_BUS 16'h0064
`define RST_PON_TIME 16'h0032
`define RST_OC_TIME 16'h0004

// Field positions of option byte 1.
`define C1_SELF 7
`define C1_HS_DIS 6
`define C1_MTT 5
`define C1_EOP 4
`define C1_SENSE_HI 3
`define C1_SENSE_LO 2
`define C1_PERPORT 1
`define C1_LED 0
// Field positions of option byte 2.
`define C2_DYN 7
`define C2_COMPOUND 6
// Control register bit.
`define CTRL_DONE 0

// Source-select strap codes; every other code means internal defaults.
`define SRC_SMBUS 3'b001
`define SRC_EEPROM 3'b010

// Current sensing modes.
`define SENSE_GANGED 2'b00
`define SENSE_PORT 2'b01
`define SENSE_NONE 2'b10

`endif

// ==== verif/hub_cfg_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module hub_cfg_checker (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire switch_polarity_strap,
    input wire upstream_supply_sense,
    input wire [3:0] over_current_in,
    input wire frame_eof1,
    input wire downstream_traffic,
    input wire [3:0] port_power_switch_outputs,
    input wire upstream_attach,
    input wire pullup_power,
    input wire [15:0] vendor_id,
    input wire hs_disabled,
    input wire [1:0] sense_mode,
    input wire [3:0] disabled_ports,
    input wire [3:0] over_current_report,
    input wire eop_send
);
    // Port power with the strap polarity removed, so one is always on.
    wire [3:0] pwr_on = port_power_switch_outputs ^ {4{~switch_polarity_strap}};
    reg [2:0] up_q;
    // The polarity is sampled after reset, so power checks wait until it has surely landed.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            up_q <= 3'h0;
        else if (up_q != 3'h7)
            up_q <= up_q + 3'h1;
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    pullup_vbus_a: assert property ((!upstream_supply_sense) [*2] |-> !pullup_power)
        else $error("pull-up powered without upstream supply");
    pullup_attach_a: assert property ((!upstream_attach) [*2] |-> !pullup_power)
        else $error("pull-up powered while detached");
    detached_off_a: assert property (up_q == 3'h7 && !upstream_attach && !$past(upstream_attach)
        |-> pwr_on == 4'h0)
        else $error("port power on while detached");
    disabled_off_a: assert property (up_q == 3'h7 |-> (pwr_on & disabled_ports) == 4'h0)
        else $error("disabled port powered");
    // Ganged sensing may report on every port while any port is in over-current.
    oc_release_a: assert property (1'b1 |=> (over_current_report & ~$past(over_current_in) &
        {4{$past(sense_mode) != 2'b00 || $past(over_current_in) == 4'h0}}) == 4'h0)
        else $error("over-current reported without input");
    // A zero delay setting lets the report follow the first cycle of the condition.
    oc_persist_a: assert property ($rose(over_current_report[1]) |-> $past(over_current_in[1]) ||
        ($past(sense_mode) == 2'b00 && $past(over_current_in) != 4'h0))
        else $error("over-current reported too early");
    eop_cause_a: assert property (eop_send |-> hs_disabled && $past(frame_eof1) && !$past(downstream_traffic))
        else $error("end of packet sent without cause");
    id_stable_a: assert property (upstream_attach && $past(upstream_attach)
        |-> $stable(vendor_id) && $stable(hs_disabled))
        else $error("configuration changed while attached");
    read_wait_a: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    okay_resp_a: assert property (hresp == 1'b0)
        else $error("response not okay");
endmodule
`default_nettype wire

// ==== verif/hub_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module hub_host_model (
    input wire hclk,
    input wire hresetn,
    input wire [3:0] want_power,
    input wire want_single,
    input wire want_traffic,
    output logic [3:0] port_power_request,
    output logic host_single_translator,
    output logic frame_start,
    output logic frame_eof1,
    output logic downstream_traffic
);
    logic [4:0] tick_q;
    // Frames repeat every 20 cycles; traffic comes well before the end-of-frame point.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_q <= 5'h0;
            {port_power_request, host_single_translator, frame_start, frame_eof1, downstream_traffic} <= 8'h0;
        end else begin
            tick_q <= (tick_q == 5'h13) ? 5'h0 : tick_q + 5'h1;
            port_power_request <= want_power;
            host_single_translator <= want_single;
            frame_start <= tick_q == 5'h0;
            downstream_traffic <= want_traffic && tick_q == 5'h5;
            frame_eof1 <= tick_q == 5'h12;
        end
    end
endmodule
`default_nettype wire

// ==== verif/hub_config_power_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module hub_config_power_control_tb;
    localparam [15:0] VID = 16'h1a2b; // Arbitrary value.
    localparam logic [15:0] IMG [14] = '{16'h1234, 16'h5678, 16'h0102, 16'h0056, 16'h0000, 16'h0000,
        16'h0008, 16'h000c, 16'h0011, 16'h0032, 16'h0022, 16'h0028, 16'h0010, 16'h0000};
    logic hclk = 1'b0, hresetn = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [1:0] htrans = 2'h0, fix = 2'h2, off = 2'h1;
    logic [2:0] src = 3'h0;
    logic sup = 1'b1, led = 1'b1, mtt = 1'b1, gang = 1'b1, pol = 1'b1, vbus = 1'b1, single = 1'b0, busy = 1'b0;
    logic [3:0] oc = 4'h0, want = 4'h1;
    wire [31:0] hrdata;
    wire hreadyout, hresp, fs, eof, traf, sgl, att, pull, selfp, hsd, mtt_o, led_o, ppp, comp, eop;
    wire [3:0] ppo, req, fixp, dis, ocr;
    wire [15:0] vid, pid, did;
    wire [1:0] sense;
    wire [7:0] maxp, hcc, pont;
    int n_errors = 0, comparisons = 0, eop_n = 0, eop_s;
    hub_config_power_control #(.DEF_VID(VID), .OC_TICK_CYCLES(20), .DETACH_CYCLES(10)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .config_source_select_hi(src[2]), .config_source_select_mid(src[1]),
        .config_source_select_lo(src[0]), .local_supply_sense(sup), .indicator_strap(led),
        .per_port_translator_strap(mtt), .common_power_switch_strap(gang), .fixed_device_port_straps(fix),
        .port_off_straps(off), .switch_polarity_strap(pol), .upstream_supply_sense(vbus),
        .host_single_translator(sgl), .port_power_request(req), .over_current_in(oc), .frame_start(fs),
        .frame_eof1(eof), .downstream_traffic(traf), .port_power_switch_outputs(ppo), .upstream_attach(att),
        .pullup_power(pull), .vendor_id(vid), .product_id(pid), .device_id(did), .self_powered(selfp),
        .hs_disabled(hsd), .multi_translator(mtt_o), .indicator_enable(led_o), .sense_mode(sense),
        .per_port_power(ppp), .compound_device(comp), .fixed_ports(fixp), .disabled_ports(dis),
        .max_power(maxp), .hub_current(hcc), .power_on_time(pont), .over_current_report(ocr), .eop_send(eop));
    hub_host_model u_host (.hclk(hclk), .hresetn(hresetn), .want_power(want), .want_single(single),
        .want_traffic(busy), .port_power_request(req), .host_single_translator(sgl), .frame_start(fs),
        .frame_eof1(eof), .downstream_traffic(traf));
    // Clock and watchdog; the tests need some 450 cycles.
    initial forever #25 hclk = ~hclk;
    initial begin
        #400000;
        n_errors++;
        test_done;
    end
    // Pulses are counted off the sampling edge so reads at the rising edge never race them.
    always @(negedge hclk) if (eop === 1'b1) eop_n++;
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic chk(input [31:0] got, input [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One single transfer; the address phase is held until ready, then the data phase likewise.
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge hclk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, a};
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++t < 20);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++t < 20);
        rd = hrdata;
        if (t >= 20) chk(t, 0);
    endtask
    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic till(input logic v);
        int t;
        for (t = 0; t < 300 && att !== v; t++) @(posedge hclk);
        chk(att, v);
    endtask
    task automatic rst(input logic [2:0] s, input logic p);
        @(posedge hclk);
        {hresetn, src, pol} <= {1'b0, s, p};
        cyc(3);
        hresetn <= 1'b1;
    endtask
    task automatic test_done;
        if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        hresetn <= 1'b0;
        rst(3'h0, 1'b1);
        till(1'b1);
        chk(vid, VID);
        chk({selfp, led_o, mtt_o, ppp, comp, hsd}, 6'b111010);
        chk({sense, fixp, dis}, {2'h0, 4'h3, 4'h8});
        chk({maxp, hcc, pont}, 24'h010132);
        chk({ppo, pull}, 5'h0f);
        rdchk(32'h3c, 32'h81f);
        bus(1'b1, 32'h0c, 32'h0);
        rdchk(32'h0c, 32'h98);
        rdchk(32'h40, 32'h0);
        single <= 1'b1;
        cyc(3);
        chk(mtt_o, 0);
        {single, oc} <= {1'b0, 4'h2};
        cyc(50);
        chk(ocr, 0);
        cyc(70);
        chk(ocr, 4'hf);
        oc <= 4'h0;
        cyc(3);
        chk(ocr, 0);
        sup <= 1'b0;
        cyc(3);
        chk({att, ppo}, 5'h0);
        till(1'b1);
        chk({selfp, sense, maxp, hcc}, {1'b0, 2'h2, 16'h6464});
        sup <= 1'b1;
        till(1'b0);
        till(1'b1);
        chk(selfp, 1);
        vbus <= 1'b0;
        cyc(3);
        chk(pull, 0);
        vbus <= 1'b1;
        cyc(3);
        chk(pull, 1);
        want <= 4'h5;
        rst(3'h2, 1'b0);
        cyc(8);
        rdchk(32'h3c, 32'h258);
        for (int i = 0; i < 14; i++) bus(1'b1, 32'(4 * i), 32'(IMG[i]));
        rdchk(32'h0c, 32'h56);
        chk(att, 0);
        bus(1'b1, 32'h38, 32'h1);
        till(1'b1);
        cyc(3);
        chk({vid, pid, did}, 48'h123456780102);
        chk({selfp, hsd, mtt_o, led_o, ppp, comp}, 6'b010010);
        chk({sense, dis, maxp, hcc, pont}, {2'h1, 4'hc, 24'h322810});
        chk(ppo, 4'he);
        oc <= 4'h2;
        cyc(3);
        chk(ocr, 4'h2);
        oc <= 4'h0;
        cyc(20);
        eop_s = eop_n;
        cyc(60);
        chk(eop_n - eop_s, 3);
        busy <= 1'b1;
        cyc(20);
        eop_s = eop_n;
        cyc(60);
        chk(eop_n - eop_s, 0);
        rst(3'h1, 1'b1);
        cyc(10);
        chk(att, 0);
        bus(1'b1, 32'h38, 32'h1);
        till(1'b1);
        rst(3'h7, 1'b1);
        till(1'b1);
        chk(vid, VID);
        test_done;
    end
endmodule
bind hub_config_power_control hub_cfg_checker u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .switch_polarity_strap, .upstream_supply_sense, .over_current_in, .frame_eof1,
    .downstream_traffic, .port_power_switch_outputs, .upstream_attach, .pullup_power, .vendor_id,
    .hs_disabled, .sense_mode, .disabled_ports, .over_current_report, .eop_send);
`default_nettype wire
